// file: rtl/mgp_consts.vh
// Purpose: constants of the port block: register map, field positions, reset values, timing
// Assumes: 50 MHz clk_sys, 32-bit Avalon-MM register window, byte addresses
// Notes:   definitions only
`ifndef MGP_CONSTS_VH
`define MGP_CONSTS_VH

// register byte offsets
`define MGP_ADDR_W          6
`define MGP_OFS_P1_LATCH    6'h00
`define MGP_OFS_P3_LATCH    6'h04
`define MGP_OFS_P1_PINS     6'h08
`define MGP_OFS_P3_PINS     6'h0c
`define MGP_OFS_CTRL        6'h10
`define MGP_OFS_SERIAL_BUFFER_REG        6'h14
`define MGP_OFS_SSTAT       6'h18
`define MGP_OFS_TCTRL       6'h1c
`define MGP_OFS_T0          6'h20
`define MGP_OFS_T1          6'h24
`define MGP_OFS_T2          6'h28
`define MGP_OFS_T2_RELOAD   6'h2c
`define MGP_OFS_T2_CAPTURE  6'h30

// reset values
`define MGP_RST_LATCH       8'hff
`define MGP_RST_CTRL        7'h00
`define MGP_RST_TCTRL       8'h00
`define MGP_RST_TIMER       16'h0000

// control register fields
`define MGP_CTRL_P1_PUD     0
`define MGP_CTRL_P3_PUD     1
`define MGP_CTRL_EXT_MODE   2
`define MGP_CTRL_REN        3
`define MGP_CTRL_SMODE_LO   4
`define MGP_CTRL_SMODE_HI   5
`define MGP_CTRL_EXTERNAL_INTERRUPT_N_EN    6

// timer control fields
`define MGP_TC_RUN_LO       0
`define MGP_TC_RUN_HI       2
`define MGP_TC_CSEL_LO      3
`define MGP_TC_CSEL_HI      5
`define MGP_TC_T1_GATE      6
`define MGP_TC_T2_EXEN      7

// serial status fields
`define MGP_SS_TX_BUSY      0
`define MGP_SS_RX_FULL      1

// serial modes
`define MGP_SMODE_SHIFT     2'h0

// pin positions
`define MGP_P3_SER_DATA     0
`define MGP_P3_SER_TX       1
`define MGP_P3_INT0         2
`define MGP_P3_INTERRUPT_INPUT_1         3
`define MGP_P3_T0_EVT       4
`define MGP_P3_T1_EVT       5
`define MGP_P3_WR           6
`define MGP_P3_RD           7
`define MGP_P1_T2_EVT       0
`define MGP_P1_T2_TRIG      1

// timing
`define MGP_MC_DIV          4'hc
`define MGP_MC_LAST         4'hb
`define MGP_MC_HALF         4'h6
`define MGP_BAUD_MC         5'h10
`define MGP_BAUD_LAST       5'h0f
`define MGP_BAUD_MID        5'h08
`define MGP_SH_BITS         4'h8
`define MGP_UART_BITS       4'ha
`define MGP_RX_BITS         4'h9

`endif

// file: rtl/mgp_gpio_ports.v
// Purpose: ports 1 and 3 with pads, pull-up control and alternate functions
// Assumes: Avalon-MM slave, byte addresses, one word per register
// Notes:   timers and serial port are reduced to what the pins need
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "mgp_consts.vh"

// How it works
// - each pad enable is active high: high drives the pin, low listens
// - enable is the inverse of output ANDed with its two-clock delayed copy
// - per-port pull-up disable bit turns that port's pull-ups off
// - after reset all latches are high and pull-ups enabled
// - port 3 alternate inputs come straight from the pad input line
// - port 3 pins stay readable while used as alternate inputs
// - port 3 bits 0 and 1 output alternate output AND latch; bits 7 and 6 ignore the latch; idle alternates rest high
// - serial mode 0: data on bit 0, clock/12 on bit 1
// - serial modes 1 to 3: receive on bit 0, transmit on bit 1, full duplex
// - serial buffer access starts transmit; otherwise serial outputs stay high
// - receive enable gates reception so bit 0 inputs do not disturb it
// - interrupt 0 merges on-chip interrupts with the bit 2 external interrupt
// - interrupt 1 comes only from port 3 bit 3
// - timer mode counts once per machine cycle, clock/12
// - counter mode counts falling edges of the timer's event pin
// - timer 1 is gated by the level on port 3 bit 3
// - timer 0 has no gating
// - timer 2 trigger on port 1 bit 1 captures or reloads
// - bits 7 and 6 carry emulator or core read and write strobes
module mgp_gpio_ports (
    input  wire        clk_sys,           // system clock
    input  wire        reset,             // synchronous reset, active high
    input  wire [5:0]  avs_address,       // byte address
    input  wire        avs_read,          // read request
    input  wire        avs_write,         // write request
    input  wire [31:0] avs_writedata,     // write data
    input  wire [3:0]  avs_byteenable,    // byte enables
    output reg  [31:0] avs_readdata,      // read data
    output reg         avs_waitrequest,   // stall
    input  wire [7:0]  p1_pad_in,         // port 1 pad levels
    output wire [7:0]  p1_pad_out,        // port 1 pad data
    output wire [7:0]  p1_pad_oe,         // port 1 driver enables
    output reg         p1_pullup_en,      // port 1 pull-ups on
    input  wire [7:0]  p3_pad_in,         // port 3 pad levels
    output wire [7:0]  p3_pad_out,        // port 3 pad data
    output wire [7:0]  p3_pad_oe,         // port 3 driver enables
    output reg         p3_pullup_en,      // port 3 pull-ups on
    input  wire        onchip_irq,        // any on-chip interrupt pending
    input  wire        core_rd_n,         // core external read strobe
    input  wire        core_wr_n,         // core external write strobe
    output reg         int0_n,            // interrupt input 0 to core
    output reg         interrupt_input_1_n,            // interrupt input 1 to core
    output reg         emu_rd_n,          // emulator read strobe
    output reg         emu_wr_n           // emulator write strobe
);
    reg  [7:0]  p1_latch_ff;
    reg  [7:0]  p3_latch_ff;
    reg  [6:0]  ctrl_ff;
    reg  [7:0]  tctrl_ff;
    reg  [15:0] t0_ff;
    reg  [15:0] t1_ff;
    reg  [15:0] t2_ff;
    reg  [15:0] t2_reload_ff;
    reg  [15:0] t2_cap_ff;
    reg  [3:0]  mc_cnt_ff;
    reg  [7:0]  p1_prev_ff;
    reg  [7:0]  p3_prev_ff;
    reg         wait_ff;
    wire [7:0]  p1_din;
    wire [7:0]  p3_din;
    wire [7:0]  p1_nxt_do;
    reg  [7:0]  p3_nxt_do;
    // serial
    reg  [7:0]  tx_data_ff;
    reg  [9:0]  tx_sh_ff;
    reg  [3:0]  tx_bits_ff;
    reg         tx_busy_ff;
    reg         tx_go_ff;
    reg  [4:0]  tx_bt_ff;
    reg         alt_data_ff;
    reg         alt_tx_ff;
    reg  [7:0]  rx_sh_ff;
    reg  [7:0]  rx_buf_ff;
    reg  [3:0]  rx_bits_ff;
    reg  [4:0]  rx_bt_ff;
    reg         rx_busy_ff;
    reg         rx_full_ff;
    reg  [31:0] nxt_rdata;

    wire        req      = avs_read | avs_write;
    wire        take     = req & ~wait_ff;
    wire        wr_take  = avs_write & take & avs_byteenable[0];
    wire        rd_take  = avs_read & take;
    wire        mc_tick  = (mc_cnt_ff == `MGP_MC_LAST);
    wire        ext_mode = ctrl_ff[`MGP_CTRL_EXT_MODE];
    wire [1:0]  smode    = ctrl_ff[`MGP_CTRL_SMODE_HI:`MGP_CTRL_SMODE_LO];
    wire        shift_md = (smode == `MGP_SMODE_SHIFT);
    wire        serial_buffer_reg_wr  = wr_take & (avs_address == `MGP_OFS_SERIAL_BUFFER_REG);
    wire        serial_buffer_reg_rd  = rd_take & (avs_address == `MGP_OFS_SERIAL_BUFFER_REG);
    wire        serial_buffer_reg_go  = serial_buffer_reg_wr | serial_buffer_reg_rd;
    wire [7:0]  tx_byte  = serial_buffer_reg_wr ? avs_writedata[7:0] : tx_data_ff;
    wire [2:0]  run      = tctrl_ff[`MGP_TC_RUN_HI:`MGP_TC_RUN_LO];
    wire [2:0]  csel     = tctrl_ff[`MGP_TC_CSEL_HI:`MGP_TC_CSEL_LO];
    // falling edges of filtered event pins
    wire        t0_fall  = p3_prev_ff[`MGP_P3_T0_EVT] & ~p3_din[`MGP_P3_T0_EVT];
    wire        t1_fall  = p3_prev_ff[`MGP_P3_T1_EVT] & ~p3_din[`MGP_P3_T1_EVT];
    wire        t2_fall  = p1_prev_ff[`MGP_P1_T2_EVT] & ~p1_din[`MGP_P1_T2_EVT];
    wire        trig     = p1_prev_ff[`MGP_P1_T2_TRIG] & ~p1_din[`MGP_P1_T2_TRIG];
    wire        t0_step  = run[0] & (csel[0] ? t0_fall : mc_tick);
    wire        t1_open  = ~tctrl_ff[`MGP_TC_T1_GATE] | p3_din[`MGP_P3_INTERRUPT_INPUT_1];
    wire        t1_step  = run[1] & t1_open & (csel[1] ? t1_fall : mc_tick);
    wire        t2_step  = run[2] & (csel[2] ? t2_fall : mc_tick);
    wire        t2_trig  = tctrl_ff[`MGP_TC_T2_EXEN] & trig;

    assign p1_nxt_do = p1_latch_ff;

    always @* begin
        p3_nxt_do = p3_latch_ff;
        p3_nxt_do[`MGP_P3_SER_DATA] = alt_data_ff & p3_latch_ff[`MGP_P3_SER_DATA];
        p3_nxt_do[`MGP_P3_SER_TX]   = alt_tx_ff & p3_latch_ff[`MGP_P3_SER_TX];
        if (ext_mode) begin
            p3_nxt_do[`MGP_P3_WR] = 1'b1;
            p3_nxt_do[`MGP_P3_RD] = 1'b1;
        end else begin
            p3_nxt_do[`MGP_P3_WR] = core_wr_n;
            p3_nxt_do[`MGP_P3_RD] = core_rd_n;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pad
            mgp_pad u_p1 (
                .clk_sys (clk_sys),
                .reset   (reset),
                .do_next (p1_nxt_do[gi]),
                .pad_in  (p1_pad_in[gi]),
                .pad_out (p1_pad_out[gi]),
                .pad_oe  (p1_pad_oe[gi]),
                .din     (p1_din[gi])
            );
            mgp_pad u_p3 (
                .clk_sys (clk_sys),
                .reset   (reset),
                .do_next (p3_nxt_do[gi]),
                .pad_in  (p3_pad_in[gi]),
                .pad_out (p3_pad_out[gi]),
                .pad_oe  (p3_pad_oe[gi]),
                .din     (p3_din[gi])
            );
        end
    endgenerate

    // register read mux
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (avs_address)
            `MGP_OFS_P1_LATCH:   nxt_rdata[7:0]  = p1_latch_ff;
            `MGP_OFS_P3_LATCH:   nxt_rdata[7:0]  = p3_latch_ff;
            `MGP_OFS_P1_PINS:    nxt_rdata[7:0]  = p1_din;
            `MGP_OFS_P3_PINS:    nxt_rdata[7:0]  = p3_din;
            `MGP_OFS_CTRL:       nxt_rdata[6:0]  = ctrl_ff;
            `MGP_OFS_SERIAL_BUFFER_REG:       nxt_rdata[7:0]  = rx_buf_ff;
            `MGP_OFS_SSTAT: begin
                nxt_rdata[`MGP_SS_TX_BUSY] = tx_busy_ff;
                nxt_rdata[`MGP_SS_RX_FULL] = rx_full_ff;
            end
            `MGP_OFS_TCTRL:      nxt_rdata[7:0]  = tctrl_ff;
            `MGP_OFS_T0:         nxt_rdata[15:0] = t0_ff;
            `MGP_OFS_T1:         nxt_rdata[15:0] = t1_ff;
            `MGP_OFS_T2:         nxt_rdata[15:0] = t2_ff;
            `MGP_OFS_T2_RELOAD:  nxt_rdata[15:0] = t2_reload_ff;
            `MGP_OFS_T2_CAPTURE: nxt_rdata[15:0] = t2_cap_ff;
            default:             nxt_rdata       = 32'h0000_0000;
        endcase
    end

    // bus slave: answer one cycle after the request appears
    always @(posedge clk_sys) begin
        if (reset) begin
            wait_ff         <= 1'b1;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            wait_ff         <= ~(req & wait_ff);
            avs_waitrequest <= ~(req & wait_ff);
            if (req & wait_ff) begin
                avs_readdata <= avs_read ? nxt_rdata : 32'h0000_0000;
            end
        end
    end

    // software registers
    always @(posedge clk_sys) begin
        if (reset) begin
            p1_latch_ff  <= `MGP_RST_LATCH;
            p3_latch_ff  <= `MGP_RST_LATCH;
            ctrl_ff      <= `MGP_RST_CTRL;
            tctrl_ff     <= `MGP_RST_TCTRL;
            t2_reload_ff <= `MGP_RST_TIMER;
            tx_data_ff   <= 8'hff;
            p1_pullup_en <= 1'b1;
            p3_pullup_en <= 1'b1;
        end else begin
            p1_pullup_en <= ~ctrl_ff[`MGP_CTRL_P1_PUD];
            p3_pullup_en <= ~ctrl_ff[`MGP_CTRL_P3_PUD];
            if (wr_take) begin
                case (avs_address)
                    `MGP_OFS_P1_LATCH:  p1_latch_ff  <= avs_writedata[7:0];
                    `MGP_OFS_P3_LATCH:  p3_latch_ff  <= avs_writedata[7:0];
                    `MGP_OFS_CTRL:      ctrl_ff      <= avs_writedata[6:0];
                    `MGP_OFS_SERIAL_BUFFER_REG:      tx_data_ff   <= avs_writedata[7:0];
                    `MGP_OFS_TCTRL:     tctrl_ff     <= avs_writedata[7:0];
                    `MGP_OFS_T2_RELOAD: t2_reload_ff <= avs_writedata[15:0];
                    default:            tctrl_ff     <= tctrl_ff;
                endcase
            end
        end
    end

    // machine cycle divider, event edge history, core-facing inputs
    always @(posedge clk_sys) begin
        if (reset) begin
            mc_cnt_ff  <= 4'h0;
            p1_prev_ff <= 8'hff;
            p3_prev_ff <= 8'hff;
            int0_n     <= 1'b1;
            interrupt_input_1_n     <= 1'b1;
            emu_rd_n   <= 1'b1;
            emu_wr_n   <= 1'b1;
        end else begin
            mc_cnt_ff  <= mc_tick ? 4'h0 : mc_cnt_ff + 4'h1;
            p1_prev_ff <= p1_din;
            p3_prev_ff <= p3_din;
            // on-chip sources share interrupt 0 with the external pin
            int0_n     <= ~onchip_irq
                          & (p3_din[`MGP_P3_INT0] | ~ctrl_ff[`MGP_CTRL_EXTERNAL_INTERRUPT_N_EN]);
            interrupt_input_1_n     <= p3_din[`MGP_P3_INTERRUPT_INPUT_1];
            emu_rd_n   <= ext_mode ? p3_din[`MGP_P3_RD] : 1'b1;
            emu_wr_n   <= ext_mode ? p3_din[`MGP_P3_WR] : 1'b1;
        end
    end

    // timers
    always @(posedge clk_sys) begin
        if (reset) begin
            t0_ff     <= `MGP_RST_TIMER;
            t1_ff     <= `MGP_RST_TIMER;
            t2_ff     <= `MGP_RST_TIMER;
            t2_cap_ff <= `MGP_RST_TIMER;
        end else begin
            if (t0_step) begin
                t0_ff <= t0_ff + 16'h0001;
            end
            if (t1_step) begin
                t1_ff <= t1_ff + 16'h0001;
            end
            if (t2_trig & ~csel[2]) begin
                t2_ff <= t2_reload_ff;
            end else if (t2_step) begin
                t2_ff <= t2_ff + 16'h0001;
            end
            if (t2_trig & csel[2]) begin
                t2_cap_ff <= t2_ff;
            end
        end
    end

    // serial transmit; idle alternates rest high
    always @(posedge clk_sys) begin
        if (reset) begin
            tx_sh_ff    <= 10'h3ff;
            tx_bits_ff  <= 4'h0;
            tx_busy_ff  <= 1'b0;
            tx_bt_ff    <= 5'h00;
            tx_go_ff    <= 1'b0;
            alt_data_ff <= 1'b1;
            alt_tx_ff   <= 1'b1;
        end else if (serial_buffer_reg_go) begin
            tx_busy_ff <= 1'b1;
            tx_go_ff   <= 1'b0;
            tx_bt_ff   <= 5'h00;
            if (shift_md) begin
                tx_sh_ff   <= {2'h3, tx_byte};
                tx_bits_ff <= `MGP_SH_BITS;
            end else begin
                tx_sh_ff   <= {1'b1, tx_byte, 1'b0};
                tx_bits_ff <= `MGP_UART_BITS;
            end
        end else if (tx_busy_ff & ~tx_go_ff) begin
            // start on a machine cycle edge so the first bit gets a full period
            alt_data_ff <= 1'b1;
            alt_tx_ff   <= 1'b1;
            tx_go_ff    <= mc_tick;
        end else if (tx_busy_ff) begin
            if (shift_md) begin
                alt_data_ff <= tx_sh_ff[0];
                alt_tx_ff   <= (mc_cnt_ff >= `MGP_MC_HALF);
                if (mc_tick) begin
                    tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
                    tx_bits_ff <= tx_bits_ff - 4'h1;
                    tx_busy_ff <= (tx_bits_ff != 4'h1);
                end
            end else begin
                alt_tx_ff <= tx_sh_ff[0];
                if (mc_tick) begin
                    tx_bt_ff <= tx_bt_ff + 5'h01;
                    if (tx_bt_ff == `MGP_BAUD_LAST) begin
                        tx_bt_ff   <= 5'h00;
                        tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
                        tx_bits_ff <= tx_bits_ff - 4'h1;
                        tx_busy_ff <= (tx_bits_ff != 4'h1);
                    end
                end
            end
        end else begin
            alt_data_ff <= 1'b1;
            alt_tx_ff   <= 1'b1;
        end
    end

    // serial receive, independent of transmit
    always @(posedge clk_sys) begin
        if (reset) begin
            rx_sh_ff   <= 8'h00;
            rx_buf_ff  <= 8'h00;
            rx_bits_ff <= 4'h0;
            rx_bt_ff   <= 5'h00;
            rx_busy_ff <= 1'b0;
            rx_full_ff <= 1'b0;
        end else begin
            if (serial_buffer_reg_rd) begin
                rx_full_ff <= 1'b0;
            end
            if (~ctrl_ff[`MGP_CTRL_REN] | shift_md) begin
                rx_busy_ff <= 1'b0;
            end else if (~rx_busy_ff) begin
                if (p3_prev_ff[`MGP_P3_SER_DATA] & ~p3_din[`MGP_P3_SER_DATA]) begin
                    rx_busy_ff <= 1'b1;
                    rx_bt_ff   <= 5'h00;
                    rx_bits_ff <= `MGP_RX_BITS;
                end
            end else if (mc_tick) begin
                rx_bt_ff <= rx_bt_ff + 5'h01;
                if (rx_bt_ff == `MGP_BAUD_LAST) begin
                    rx_bt_ff <= 5'h00;
                end
                if (rx_bt_ff == `MGP_BAUD_MID) begin
                    rx_bits_ff <= rx_bits_ff - 4'h1;
                    if (rx_bits_ff == `MGP_RX_BITS) begin
                        rx_busy_ff <= ~p3_din[`MGP_P3_SER_DATA];
                    end else begin
                        rx_sh_ff <= {p3_din[`MGP_P3_SER_DATA], rx_sh_ff[7:1]};
                    end
                    if (rx_bits_ff == 4'h1) begin
                        rx_busy_ff <= 1'b0;
                        rx_buf_ff  <= {p3_din[`MGP_P3_SER_DATA], rx_sh_ff[7:1]};
                        rx_full_ff <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // mgp_gpio_ports

// file: rtl/mgp_pad.v
// Purpose: one port bit: registered pad data, delayed enable, filtered pad input
// Assumes: pad_in arrives from outside the clk_sys domain
// Notes:   enable high means the output driver is on
`timescale 1ns/10ps
module mgp_pad (
    input  wire clk_sys,   // system clock
    input  wire reset,     // synchronous reset, active high
    input  wire do_next,   // next pad output level
    input  wire pad_in,    // raw pad level
    output reg  pad_out,   // pad output level
    output reg  pad_oe,    // output driver enable
    output reg  din        // filtered pad input line
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg do_d1_ff;

    always @(posedge clk_sys) begin
        if (reset) begin
            pad_out  <= 1'b1;
            do_d1_ff <= 1'b1;
            pad_oe   <= 1'b0;
            s1_ff    <= 1'b1;
            s2_ff    <= 1'b1;
            s3_ff    <= 1'b1;
            din      <= 1'b1;
        end else begin
            pad_out  <= do_next;
            do_d1_ff <= pad_out;
            // enable is the inverse of data AND two-clock delayed data
            pad_oe   <= ~(do_next & do_d1_ff);
            s1_ff    <= pad_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            if (s2_ff == s3_ff) begin
                din <= s3_ff;
            end
        end
    end
endmodule // mgp_pad

// file: tb/mgp_gpio_ports_asserts.sv
// Purpose: concurrent checks on the port block's ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every instance of the block
`timescale 1ns/10ps
module mgp_gpio_ports_chk (
    input wire        clk_sys,         // clock
    input wire        reset,           // reset
    input wire [5:0]  avs_address,     // address
    input wire        avs_read,        // read
    input wire        avs_write,       // write
    input wire [31:0] avs_writedata,   // write data
    input wire [3:0]  avs_byteenable,  // byte enables
    input wire [31:0] avs_readdata,    // read data
    input wire        avs_waitrequest, // stall
    input wire [7:0]  p1_pad_out,      // port 1 data
    input wire [7:0]  p1_pad_oe,       // port 1 drive
    input wire        p1_pullup_en,    // port 1 pull-ups
    input wire [7:0]  p3_pad_in,       // port 3 pins
    input wire [7:0]  p3_pad_out,      // port 3 data
    input wire [7:0]  p3_pad_oe,       // port 3 drive
    input wire        p3_pullup_en,    // port 3 pull-ups
    input wire        onchip_irq,      // on-chip interrupt
    input wire        int0_n,          // interrupt 0
    input wire        interrupt_input_1_n,          // interrupt 1
    input wire        emu_rd_n,        // emulator read
    input wire        emu_wr_n         // emulator write
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_p1_drive_hold: assert property (p1_pad_oe == ~(p1_pad_out & $past(p1_pad_out, 2)))
        else $error("port 1 enable wrong");
    a_p3_drive_hold: assert property (
        p3_pad_oe[5:0] == ~(p3_pad_out[5:0] & $past(p3_pad_out[5:0], 2)))
        else $error("port 3 enable wrong");
    a_pullup_write: assert property ((avs_write && !avs_waitrequest && avs_address == 6'h10
        && avs_byteenable[0]) |-> ##2
        ({p3_pullup_en, p1_pullup_en} == ~$past(avs_writedata[1:0], 2)))
        else $error("pull-up enables wrong");
    a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest ##1
        avs_waitrequest) else $error("bus answer wrong");
    a_unmapped_read: assert property ((avs_read && !avs_waitrequest && (avs_address[1:0] != 2'h0
        || avs_address > 6'h30)) |-> avs_readdata == 32'h0) else $error("unmapped read wrong");
    a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_interrupt_input_1_follow: assert property ($stable(p3_pad_in[3]) [*7] |-> interrupt_input_1_n == p3_pad_in[3])
        else $error("interrupt 1 wrong");
    a_int0_onchip: assert property (onchip_irq [*3] |-> !int0_n)
        else $error("interrupt 0 wrong");
    a_strobe_mode: assert property ((!emu_rd_n || !emu_wr_n) |-> p3_pad_out[7:6] == 2'h3)
        else $error("strobe pins driven");
endmodule // mgp_gpio_ports_chk

bind mgp_gpio_ports mgp_gpio_ports_chk u_chk (.clk_sys, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .p1_pad_out,
    .p1_pad_oe, .p1_pullup_en, .p3_pad_in, .p3_pad_out, .p3_pad_oe, .p3_pullup_en, .onchip_irq,
    .int0_n, .interrupt_input_1_n, .emu_rd_n, .emu_wr_n);

// file: tb/mgp_gpio_ports_test.sv
// Purpose: self-checking bench of the port block
// Assumes: 50 MHz clk_sys, one pin model per port
// Notes:   registers reached through the bus task
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
    failures = failures + 1; $display("wrong value %s expected %h seen %h", n, e, g); end end
module mgp_gpio_ports_test;
    reg         clk_sys = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, prv;
    reg         onchip_irq = 1'b0, core_rd_n = 1'b1, core_wr_n = 1'b1, lp = 1'b0;
    reg  [5:0]  avs_address = 6'h00;
    reg  [31:0] avs_writedata = 32'h0, rd;
    reg  [3:0]  avs_byteenable = 4'hf;
    reg  [7:0]  p3_lo = 8'h00, sh;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, p1_pullup_en, p3_pullup_en, int0_n, interrupt_input_1_n, emu_rd_n, emu_wr_n;
    wire [7:0]  p1_pad_in, p1_pad_out, p1_pad_oe, p3_pad_in, p3_pad_out, p3_pad_oe;
    integer     failures = 0, total_checks = 0, cyc = 0, i, n;
    mgp_gpio_ports dut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .p1_pad_in, .p1_pad_out, .p1_pad_oe,
        .p1_pullup_en, .p3_pad_in, .p3_pad_out, .p3_pad_oe, .p3_pullup_en, .onchip_irq,
        .core_rd_n, .core_wr_n, .int0_n, .interrupt_input_1_n, .emu_rd_n, .emu_wr_n);
    mgp_pin_world u_p1 (.clk_sys, .pad_out(p1_pad_out), .pad_oe(p1_pad_oe),
        .pullup_en(p1_pullup_en), .sink_lo(8'h00), .pad_in(p1_pad_in));
    // loopback: the transmit pin sinks the receive pin
    mgp_pin_world u_p3 (.clk_sys, .pad_out(p3_pad_out), .pad_oe(p3_pad_oe),
        .pullup_en(p3_pullup_en), .sink_lo(p3_lo | {7'h00, lp & ~p3_pad_out[1]}),
        .pad_in(p3_pad_in));
    always #10 clk_sys = ~clk_sys;
    task tally_and_finish; begin
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            failures = failures + 1;
            tally_and_finish;
        end
    end
    task bus(input w, input [5:0] a, input [31:0] d); begin
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    end endtask
    task rchk(input [5:0] a, input [31:0] e); begin
        bus(1'b0, a, 32'h0);
        `CHK("register", e, rd)
    end endtask
    // event source holds each level 14 clocks
    task ev(input integer k); begin
        for (i = 0; i < k; i = i + 1) begin
            p3_lo <= p3_lo | 8'h20;
            repeat (14) @(posedge clk_sys);
            p3_lo <= p3_lo & 8'hdf;
            repeat (14) @(posedge clk_sys);
        end
    end endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rchk(6'h00, 32'hff);
        rchk(6'h10, 32'h00);
        `CHK("pull-ups", 2'h3, {p3_pullup_en, p1_pullup_en})
        `CHK("serial idle", 2'h3, p3_pad_out[1:0])
        bus(1'b1, 6'h00, 32'h5a);
        repeat (2) @(posedge clk_sys);
        `CHK("p1 enable", 8'ha5, p1_pad_oe)
        repeat (4) @(posedge clk_sys);
        rchk(6'h08, 32'h5a);
        bus(1'b1, 6'h00, 32'hff);
        repeat (3) @(posedge clk_sys);
        `CHK("p1 held", 8'ha5, p1_pad_oe)
        @(posedge clk_sys);
        `CHK("p1 released", 8'h00, p1_pad_oe)
        bus(1'b1, 6'h10, 32'h03);
        repeat (3) @(posedge clk_sys);
        `CHK("pull-ups", 2'h0, {p3_pullup_en, p1_pullup_en})
        bus(1'b1, 6'h10, 32'h00);
        rchk(6'h34, 32'h0);
        p3_lo <= 8'h08;
        repeat (8) @(posedge clk_sys);
        `CHK("interrupt_input_1", 1'b0, interrupt_input_1_n)
        rchk(6'h0c, 32'hf7);
        p3_lo <= 8'h04;
        onchip_irq <= 1'b1;
        repeat (4) @(posedge clk_sys);
        `CHK("int0 on-chip", 1'b0, int0_n)
        onchip_irq <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHK("int0 masked", 1'b1, int0_n)
        bus(1'b1, 6'h10, 32'h40);
        repeat (6) @(posedge clk_sys);
        `CHK("int0 pin", 1'b0, int0_n)
        p3_lo <= 8'h00;
        bus(1'b1, 6'h10, 32'h00);
        bus(1'b1, 6'h04, 32'hfb);
        {core_rd_n, core_wr_n} <= 2'h0;
        repeat (3) @(posedge clk_sys);
        `CHK("p3 data", 8'h3b, p3_pad_out)
        {core_rd_n, core_wr_n} <= 2'h3;
        bus(1'b1, 6'h04, 32'hff);
        bus(1'b1, 6'h10, 32'h04);
        p3_lo <= 8'h80;
        repeat (8) @(posedge clk_sys);
        `CHK("emulator strobes", 2'h1, {emu_rd_n, emu_wr_n})
        p3_lo <= 8'h00;
        bus(1'b1, 6'h10, 32'h00);
        bus(1'b1, 6'h1c, 32'h01);
        repeat (120) @(posedge clk_sys);
        bus(1'b1, 6'h1c, 32'h00);
        bus(1'b0, 6'h20, 32'h0);
        `CHK("t0 count", 1'b1, rd >= 9 && rd <= 11)
        bus(1'b1, 6'h1c, 32'h12);
        ev(3);
        rchk(6'h24, 32'h3);
        bus(1'b1, 6'h1c, 32'h52);
        p3_lo <= 8'h08;
        repeat (8) @(posedge clk_sys);
        ev(2);
        rchk(6'h24, 32'h3);
        p3_lo <= 8'h00;
        bus(1'b1, 6'h1c, 32'h00);
        bus(1'b1, 6'h14, 32'ha5);
        prv = 1'b1;
        n = 0;
        for (i = 0; i < 120; i = i + 1) begin
            @(posedge clk_sys);
            if (p3_pad_out[1] && !prv) begin
                sh = {p3_pad_out[0], sh[7:1]};
                n = n + 1;
            end
            prv = p3_pad_out[1];
        end
        `CHK("shift data", 8'ha5, sh)
        `CHK("shift clocks", 8, n)
        `CHK("serial idle", 2'h3, p3_pad_out[1:0])
        bus(1'b1, 6'h10, 32'h18);
        lp <= 1'b1;
        bus(1'b1, 6'h14, 32'h3c);
        repeat (2000) @(posedge clk_sys);
        rchk(6'h18, 32'h2);
        rchk(6'h14, 32'h3c);
        rchk(6'h18, 32'h1);
        tally_and_finish;
    end
endmodule // mgp_gpio_ports_test

// file: tb/mgp_pin_world.sv
// Purpose: devices on one port's pins
// Assumes: weak pull-up, external sinks
// Notes:   a released line without pull-up toggles each clock
`timescale 1ns/10ps
module mgp_pin_world (
    input  wire       clk_sys,   // clock
    input  wire [7:0] pad_out,   // pad data
    input  wire [7:0] pad_oe,    // pad drive
    input  wire       pullup_en, // pull-ups on
    input  wire [7:0] sink_lo,   // source pulls pin low
    output wire [7:0] pad_in     // pin level
);
    reg flt_ff = 1'b0;
    always @(posedge clk_sys) begin
        flt_ff <= ~flt_ff;
    end
    // the driver wins; a sink beats the weak pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~sink_lo & {8{pullup_en | flt_ff}});
endmodule // mgp_pin_world
